// >>> verilog/dseq_regs.vh
// Constants for the dual output enable sequencer: register offsets, field positions,
// reset values and timing counts. Included by the top design file of the block only; the synchroniser does not include it.
`ifndef DSEQ_REGS_VH
`define DSEQ_REGS_VH

// Register index of the output sequence configuration register.
`define DSEQ_OUTPUT_SEQUENCE_CONFIG_IDX 8'h02
`define DSEQ_CFG_RESET                  8'h00
// Field positions inside the configuration register.
`define DSEQ_CFG_CH0_EN_BIT             0
`define DSEQ_CFG_CH1_EN_BIT             1
`define DSEQ_CFG_SEQ_LO                 2
`define DSEQ_CFG_SEQ_HI                 3
`define DSEQ_CFG_RST_MODE_BIT           4
`define DSEQ_CFG_PG_LO                  6
`define DSEQ_CFG_PG_HI                  7
// Auto-sequence field codes.
`define DSEQ_SEQ_INDEP                  2'h0
`define DSEQ_SEQ_CH1_ON_CH0             2'h1
`define DSEQ_SEQ_CH0_ON_CH1             2'h2
`define DSEQ_SEQ_TOGETHER               2'h3
// Chip state codes.
`define DSEQ_ST_SHUTDOWN                2'h0
`define DSEQ_ST_STANDBY                 2'h1
`define DSEQ_ST_ACTIVE                  2'h2
// Reset-mode delay: 125 ms at 50 ns clock period.
`define DSEQ_RESET_DELAY_MS             125
`define DSEQ_CLK_PERIOD_NS              50
`define DSEQ_RESET_DELAY_CYC            ((`DSEQ_RESET_DELAY_MS * 1000000) / `DSEQ_CLK_PERIOD_NS)
`define DSEQ_CNT_W                      22

`endif

// >>> verilog/dseq_sync2.v
// Two flip-flop synchroniser for a bus of asynchronous levels.
// Assumes the inputs are quasi-static levels from pins or analog comparators.
`timescale 1ns/1ps
module dseq_sync2
#(
    parameter W = 1
)
(
    input  wire         ref_clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// >>> verilog/dseq_top.v
// Output enable sequencer: combines enable pins, software enable bits and the
// auto-sequence mode into channel enables, chip state and the power-good/reset pin.
// Assumes a byte-wide register port from the serial interface block on ref_clk_i.
`timescale 1ns/1ps
`include "dseq_regs.vh"
module dseq_top
#(
    parameter DUAL         = 1,
    parameter RESET_DELAY  = `DSEQ_RESET_DELAY_CYC
)
(
    input  wire       ref_clk_i,
    input  wire       rst_i,
    input  wire       chan0_enable_pin_i,
    input  wire       chan1_enable_pin_i,
    input  wire       chan0_good_i,
    input  wire       chan1_good_i,
    input  wire       input_undervoltage_lockout_i,
    input  wire       overcurrent_fault_i,
    input  wire       overtemperature_fault_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    input  wire       reg_wr_i,
    output reg  [7:0] reg_rdata_o,
    output reg        output_channel_zero_o,
    output reg        output_channel_one_o,
    output reg  [1:0] chip_state_o,
    output reg        power_good_reset_out_o,
    output reg        power_good_reset_out_oe_n_o
);
    wire [6:0] sync_w;
    reg  [7:0] cfg_q;
    reg  [`DSEQ_CNT_W-1:0] dly_q;
    reg  [`DSEQ_CNT_W-1:0] dly_d;
    reg        req0;
    reg        req1;
    reg        on0_d;
    reg        on1_d;
    reg        good_raw;
    reg  [1:0] state_d;

    wire pin0 = sync_w[0];
    wire pin1 = sync_w[1];
    wire good0 = sync_w[2];
    wire good1 = sync_w[3];
    wire input_undervoltage_lockout = sync_w[4];
    wire fault = sync_w[5] | sync_w[6];
    wire [1:0] seq = cfg_q[`DSEQ_CFG_SEQ_HI:`DSEQ_CFG_SEQ_LO];
    wire [1:0] pgsel = cfg_q[`DSEQ_CFG_PG_HI:`DSEQ_CFG_PG_LO];

    // All pin and comparator levels pass two flip-flops first.
    dseq_sync2 #(.W(7)) u_sync
    (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .async_i   ({overtemperature_fault_i, overcurrent_fault_i,
                     input_undervoltage_lockout_i, chan1_good_i, chan0_good_i,
                     chan1_enable_pin_i, chan0_enable_pin_i}),
        .sync_o    (sync_w)
    );

    always @(posedge ref_clk_i)
    begin
        if (rst_i)
            cfg_q <= `DSEQ_CFG_RESET;
        else if (reg_wr_i && reg_addr_i == `DSEQ_OUTPUT_SEQUENCE_CONFIG_IDX)
            cfg_q <= reg_wdata_i;
    end

    always @*
    begin
        req0 = pin0 & cfg_q[`DSEQ_CFG_CH0_EN_BIT];
        req1 = (DUAL != 0) & pin1 & cfg_q[`DSEQ_CFG_CH1_EN_BIT];
        on0_d = req0;
        on1_d = req1;
        case (seq)
            `DSEQ_SEQ_CH1_ON_CH0:
            begin
                // Channel zero stays on while channel one is still on, so it drops last.
                on0_d = req0 | (output_channel_zero_o & output_channel_one_o);
                on1_d = req1 & req0 & output_channel_zero_o & good0;
            end
            `DSEQ_SEQ_CH0_ON_CH1:
            begin
                // Channel one stays on while channel zero is still on, so it drops last.
                on1_d = req1 | (output_channel_one_o & output_channel_zero_o);
                on0_d = req0 & req1 & output_channel_one_o & good1;
            end
            `DSEQ_SEQ_TOGETHER:
            begin
                on0_d = req0 & req1;
                on1_d = req0 & req1;
            end
            default:
            begin
                on0_d = req0;
                on1_d = req1;
            end
        endcase
        if ((seq != `DSEQ_SEQ_INDEP) && fault)
        begin
            on0_d = 1'b0;
            on1_d = 1'b0;
        end
        if (input_undervoltage_lockout)
        begin
            on0_d = 1'b0;
            on1_d = 1'b0;
        end
        if (!pin0 && !(pin1 && DUAL != 0))
            state_d = `DSEQ_ST_SHUTDOWN;
        else if (on0_d || on1_d)
            state_d = `DSEQ_ST_ACTIVE;
        else
            state_d = `DSEQ_ST_STANDBY;
        if (DUAL == 0)
            good_raw = pgsel[1] ? (pgsel[0] | good0) : good0;
        else
        begin
            case (pgsel)
                2'h0: good_raw = good0 & good1;
                2'h1: good_raw = good1;
                2'h2: good_raw = good0;
                default: good_raw = 1'b1;
            endcase
        end
        if (!good_raw)
            dly_d = {`DSEQ_CNT_W{1'b0}};
        else if (dly_q != RESET_DELAY[`DSEQ_CNT_W-1:0])
            dly_d = dly_q + 1'b1;
        else
            dly_d = dly_q;
    end

    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            output_channel_zero_o       <= 1'b0;
            output_channel_one_o        <= 1'b0;
            chip_state_o                <= `DSEQ_ST_SHUTDOWN;
            dly_q                       <= {`DSEQ_CNT_W{1'b0}};
            power_good_reset_out_o      <= 1'b0;
            power_good_reset_out_oe_n_o <= 1'b0;
            reg_rdata_o                 <= 8'h00;
        end
        else
        begin
            output_channel_zero_o <= on0_d;
            output_channel_one_o  <= on1_d;
            chip_state_o          <= state_d;
            dly_q                 <= dly_d;
            power_good_reset_out_o <= 1'b0;
            // Released (enable high) in power-good mode when good, in reset mode after RESET_DELAY cycles of good; driven low otherwise.
            if (cfg_q[`DSEQ_CFG_RST_MODE_BIT])
                power_good_reset_out_oe_n_o <= (dly_q == RESET_DELAY[`DSEQ_CNT_W-1:0]);
            else
                power_good_reset_out_oe_n_o <= good_raw;
            reg_rdata_o <= (reg_addr_i == `DSEQ_OUTPUT_SEQUENCE_CONFIG_IDX) ? cfg_q : 8'h00;
        end
    end
endmodule

// >>> verification/dseq_monitor.sv
// Port checker of the sequencer, bound to dseq_top.
// Assumes DUAL=1 and the three-edge pin latency of the design.
`timescale 1ns/1ps
module dseq_monitor (
    input wire logic       ref_clk_i, rst_i, chan0_enable_pin_i, chan1_enable_pin_i,
    input wire logic       input_undervoltage_lockout_i, overcurrent_fault_i,
    input wire logic       overtemperature_fault_i, reg_wr_i, output_channel_zero_o,
    input wire logic       output_channel_one_o, power_good_reset_out_o,
    input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
    input wire logic [1:0] chip_state_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] cfg_q;
    wire  [1:0] m  = cfg_q[3:2];
    wire        c0 = output_channel_zero_o;
    wire        c1 = output_channel_one_o;
    always @(posedge ref_clk_i)
        if (rst_i) cfg_q <= 8'h00;
        else if (reg_wr_i && reg_addr_i == 8'h02) cfg_q <= reg_wdata_i;
    a_input_undervoltage_lockout_off: assert property (input_undervoltage_lockout_i [*4] |=> !c0 && !c1)
        else $error("output on in lockout");
    a_shdn_off: assert property ((!chan0_enable_pin_i && !chan1_enable_pin_i) [*5]
        |=> chip_state_o == 2'h0 && !c0 && !c1) else $error("no shutdown");
    a_pg_drive: assert property (!power_good_reset_out_o) else $error("pg drives high");
    a_seq_one: assert property (m == 2'h1 && $stable(cfg_q) && c1 |-> c0)
        else $error("ch1 without ch0");
    a_seq_two: assert property (m == 2'h2 && $stable(cfg_q) && c0 |-> c1)
        else $error("ch0 without ch1");
    a_seq_tog: assert property (m == 2'h3 && $stable(cfg_q) |-> c0 == c1)
        else $error("not together");
    a_fault_off: assert property ((m != 2'h0 && (overcurrent_fault_i ||
        overtemperature_fault_i)) [*5] |=> !c0 && !c1) else $error("fault left on");
    a_state_act: assert property (chip_state_o == 2'h2 |-> $past(chan0_enable_pin_i, 3)
        || $past(chan1_enable_pin_i, 3)) else $error("active without pin");
    a_read_back: assert property (reg_rdata_o == ($past(reg_addr_i) == 8'h02 ?
        $past(cfg_q) : 8'h00)) else $error("read data wrong");
endmodule
bind dseq_top dseq_monitor u_mon (.ref_clk_i, .rst_i, .chan0_enable_pin_i, .chan1_enable_pin_i,
    .input_undervoltage_lockout_i, .overcurrent_fault_i, .overtemperature_fault_i, .reg_wr_i,
    .output_channel_zero_o, .output_channel_one_o, .power_good_reset_out_o, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .chip_state_o);

// >>> verification/dseq_host.sv
// Host model: drives the enable pins and the register write port.
// Assumes the bench calls put from one process only.
`timescale 1ns/1ps
module dseq_host (
    input  wire logic       clk_i,
    output logic            pin0_o, pin1_o, wr_o,
    output logic [7:0]      addr_o, wdata_o
);
    initial {pin0_o, pin1_o, wr_o, addr_o, wdata_o} = 19'h0;
    task automatic put(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {pin1_o, pin0_o} = p;
        {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
        @(negedge clk_i);
        wr_o = 1'b0;
    endtask
endmodule

// >>> verification/test_dual_output_enable_sequencer.sv
// Self-checking bench of dseq_top against a behavioural model.
// Assumes channel good levels follow the channel enables half a cycle later.
`timescale 1ns/1ps
module test_dual_output_enable_sequencer;
    logic clk = 0, rst = 1, uv = 0, oc = 0, ot = 0, g0 = 0, g1 = 0, p0, p1, wr;
    logic c0, c1, pg, oe, x0, x1, xp;
    logic [7:0] a, d, rd, r8, cfg = 8'h00;
    logic [1:0] st;
    int fail_count = 0, comparisons = 0, cyc = 0, i;
    bit [31:0] r;
    always #25 clk = ~clk;
    dseq_host u_host (.clk_i(clk), .pin0_o(p0), .pin1_o(p1), .wr_o(wr), .addr_o(a), .wdata_o(d));
    dseq_top #(.DUAL(1), .RESET_DELAY(20)) u_dseq_top (.ref_clk_i(clk), .rst_i(rst),
        .chan0_enable_pin_i(p0), .chan1_enable_pin_i(p1), .chan0_good_i(g0), .chan1_good_i(g1),
        .input_undervoltage_lockout_i(uv), .overcurrent_fault_i(oc),
        .overtemperature_fault_i(ot), .reg_addr_i(a), .reg_wdata_i(d), .reg_wr_i(wr),
        .reg_rdata_o(rd), .output_channel_zero_o(c0), .output_channel_one_o(c1),
        .chip_state_o(st), .power_good_reset_out_o(pg), .power_good_reset_out_oe_n_o(oe));
    always @(negedge clk) {g0, g1} <= {c0, c1};
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            results;
        end
    end
    task chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task results;
        if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        r = $urandom(46896);
        repeat (8) @(negedge clk);
        rst = 0;
        for (i = 0; i < 60; i++)
        begin
            r = $urandom;
            u_host.put(r[1:0], r[2] ? 8'h02 : 8'h03, r[15:8]);
            {uv, oc, ot} = {&r[18:16], &r[20:19], &r[22:21]};
            if (r[2]) cfg = r[15:8];
            x0 = r[0] & cfg[0] & (!cfg[3] | (r[1] & cfg[1]));
            x1 = r[1] & cfg[1] & (!cfg[2] | (r[0] & cfg[0]));
            if (uv || (cfg[3:2] != 2'h0 && (oc || ot))) {x0, x1} = 2'b00;
            xp = cfg[7:6] == 2'h3 || (x0 | cfg[6]) && (x1 | cfg[7]);
            repeat (45) @(negedge clk);
            chk({6'h0, c0, c1}, {6'h0, x0, x1});
            r8 = (!r[0] && !r[1]) ? 8'h00 : (x0 | x1) ? 8'h02 : 8'h01;
            chk({6'h0, st}, r8);
            chk(rd, a == 8'h02 ? cfg : 8'h00);
            chk({7'h0, oe}, {7'h0, xp});
            chk({7'h0, pg}, 8'h00);
        end
        results;
    end
endmodule
